// ===== core/osc_status_i2c.sv
`timescale 1ns/1ps
// Operation
// - Status registers read-only; snapshot refreshed at 1 kHz.
// - Combined-offset register reports pull value plus applied aging compensation.
// - Oven-settled register reads 1 when oven is stable and controlling.
// - Thermal-loop error register reports loop deviation in degrees Celsius.
// - Heater power goal register reports target heater power in watts.
// - Fault register reads 7 in normal operation, other values mean error.
// - Fault value stays sticky until the clear sequence.
// - Target only, up to 400 kHz, may stretch SCL low.
// - SDA changes only while SCL low, stable while high.
// - Repeated START begins a new transfer.
// - Bytes are 8 bits, multi-byte values least significant byte first.
// - Receiver pulls SDA low on ninth clock to acknowledge.
// - Not-acknowledge only on address mismatch; acknowledge everything else.
// - Seven-bit address then direction bit, 1 read, 0 write.
// - Register numbers are 8 bits, 0x00 to 0xFF.
// - Register number auto-increments on reads only, inside one group.
// - Own address is 0x60 with low four bits from the option.
// - Float registers use sign, 8-bit exponent, 23-bit fraction layout.
module osc_status_i2c
    import osc_status_pkg::*;
#(
    parameter int REFRESH_DIV = REFRESH_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Address option strap
    input wire logic [OPTION_W-1:0] addr_option,
    // Live status from the oven logic
    input wire status_live_s status_live,
    input wire logic [31:0] fault_code,
    // I2C clock pin, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    // I2C data pin, open drain
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Status towards the rest of the device
    output logic refresh_tick,
    output logic fault_clear
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RECV,
        ST_RECV_ACK,
        ST_SEND,
        ST_SEND_ACK,
        ST_IGNORE
    } bus_state_e;

    bus_state_e state_reg;
    logic [1:0] pins_s;
    logic scl_s, sda_s, scl_q, sda_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [6:0] own_addr_reg;
    logic [31:0] div_reg;
    logic [9:0] tick_count_reg;
    logic [31:0] uptime_reg;
    status_live_s snap_reg;
    logic [31:0] fault_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic read_reg;
    logic [7:0] reg_num_reg;
    logic [7:0] reg_num_next;
    logic [1:0] byte_idx_reg;
    logic [1:0] wr_count_reg;
    logic clear_armed_reg;
    logic [31:0] word_mux;
    logic [31:0] word_reg;
    logic [7:0] tx_reg;
    logic [7:0] stretch_reg;
    logic addr_match;

    // Pin inputs through two flip-flops
    pin_sync #(.W(2)) u_pin_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in({scl_i, sda_i}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Previous synchronised levels for edge detection
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Bus events
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;

    // Own address follows the strap whenever the bus is idle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            own_addr_reg <= TARGET_ADDR_BASE;
        end else if (state_reg == ST_IDLE) begin
            own_addr_reg <= TARGET_ADDR_BASE | {3'h0, addr_option};
        end
    end

    assign addr_match = (shift_reg[7:1] == own_addr_reg);

    // 1 kHz refresh divider
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= 32'h0000_0000;
            refresh_tick <= 1'b0;
        end else if (div_reg == 32'(REFRESH_DIV - 1)) begin
            div_reg <= 32'h0000_0000;
            refresh_tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h0000_0001;
            refresh_tick <= 1'b0;
        end
    end

    // Seconds since power-up, counted in refresh ticks
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick_count_reg <= 10'h000;
            uptime_reg <= STATUS_RESET;
        end else if (refresh_tick) begin
            if (tick_count_reg == 10'(TICKS_PER_SECOND - 1)) begin
                tick_count_reg <= 10'h000;
                uptime_reg <= uptime_reg + 32'h0000_0001;
            end else begin
                tick_count_reg <= tick_count_reg + 10'h001;
            end
        end
    end

    // Status snapshot taken once per refresh tick
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            snap_reg <= '0;
        end else if (refresh_tick) begin
            snap_reg <= status_live;
        end
    end

    // Sticky fault value; a new fault wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fault_reg <= FAULT_NORMAL;
        end else if (refresh_tick && fault_code != FAULT_NORMAL
                     && (fault_reg == FAULT_NORMAL || fault_clear)) begin
            fault_reg <= fault_code;
        end else if (fault_clear) begin
            fault_reg <= FAULT_NORMAL;
        end
    end

    // Read data select; reserved numbers read zero
    always_comb begin
        word_mux = STATUS_RESET;
        case (reg_num_reg)
            REG_UPTIME: word_mux = uptime_reg;
            REG_RESONATOR_TEMP: word_mux = snap_reg.resonator_temp;
            REG_SUPPLY_VOLTS: word_mux = snap_reg.supply_volts;
            REG_HEATER_POWER_NOW: word_mux = snap_reg.heater_power_now;
            REG_COMBINED_OFFSET: word_mux = snap_reg.combined_offset;
            REG_FAULT_INDICATOR: word_mux = fault_reg;
            REG_OVEN_SETTLED: word_mux = {31'h0, snap_reg.oven_settled};
            REG_THERMAL_LOOP_ERROR: word_mux = snap_reg.thermal_loop_error;
            REG_HEATER_POWER_GOAL: word_mux = snap_reg.heater_power_goal;
            default: word_mux = STATUS_RESET;
        endcase
    end

    // Next register number, held at the end of its group
    always_comb begin
        reg_num_next = reg_num_reg + 8'h01;
        if (reg_num_next[7:GROUP_LSB] != reg_num_reg[7:GROUP_LSB]) begin
            reg_num_next = reg_num_reg;
        end
    end

    // Bus protocol state machine
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            read_reg <= 1'b0;
        end else if (start_seen) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
        end else if (stop_seen) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_ADDR, ST_RECV: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_RECV) begin
                            state_reg <= ST_RECV_ACK;
                        end else if (addr_match) begin
                            state_reg <= ST_ADDR_ACK;
                            read_reg <= shift_reg[0];
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RECV_ACK: begin
                    if (scl_fall) begin
                        state_reg <= read_reg ? ST_SEND : ST_RECV;
                    end
                end
                ST_SEND: begin
                    // SDA still held low late in the stretch means a STOP is coming
                    if (stretch_reg == 8'h02 && !sda_s) begin
                        state_reg <= ST_IGNORE;
                    end else if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_SEND_ACK;
                    end
                end
                ST_SEND_ACK: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                    end else if (scl_fall) begin
                        state_reg <= shift_reg[0] ? ST_IGNORE : ST_SEND;
                    end
                end
                ST_IGNORE, ST_IDLE: begin
                    state_reg <= state_reg;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Register number, byte index and write byte counting
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_num_reg <= 8'h00;
            byte_idx_reg <= 2'h0;
            wr_count_reg <= 2'h0;
        end else if (start_seen) begin
            byte_idx_reg <= 2'h0;
            wr_count_reg <= 2'h0;
        end else if (state_reg == ST_RECV && scl_fall && bit_cnt_reg == 4'h8) begin
            if (wr_count_reg == 2'h0) begin
                reg_num_reg <= shift_reg;
            end
            if (wr_count_reg != 2'h3) begin
                wr_count_reg <= wr_count_reg + 2'h1;
            end
        end else if (state_reg == ST_SEND_ACK && scl_fall && !shift_reg[0]) begin
            byte_idx_reg <= byte_idx_reg + 2'h1;
            if (byte_idx_reg == LAST_BYTE) begin
                reg_num_reg <= reg_num_next;
            end
        end
    end

    // Clear sequence: number, two bytes, then STOP; extra bytes disarm it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clear_armed_reg <= 1'b0;
            fault_clear <= 1'b0;
        end else begin
            fault_clear <= stop_seen && clear_armed_reg;
            if (start_seen || stop_seen) begin
                clear_armed_reg <= 1'b0;
            end else if (state_reg == ST_RECV && scl_fall && bit_cnt_reg == 4'h8) begin
                clear_armed_reg <= (wr_count_reg == 2'h2) && (reg_num_reg == CLEAR_REG)
                                   && (shift_reg == CLEAR_BYTE1) && clear_armed_reg;
                if (wr_count_reg == 2'h1) begin
                    clear_armed_reg <= (reg_num_reg == CLEAR_REG) && (shift_reg == CLEAR_BYTE0);
                end
            end
        end
    end

    // Word latched at byte 0 so one value never tears across its bytes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            word_reg <= STATUS_RESET;
        end else if (stretch_reg == 8'h03 && byte_idx_reg == 2'h0) begin
            word_reg <= word_mux;
        end
    end

    // Clock stretch while the next read byte is prepared
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stretch_reg <= 8'h00;
        end else if (scl_fall && read_reg
                     && (state_reg == ST_ADDR_ACK || state_reg == ST_SEND_ACK)) begin
            stretch_reg <= 8'(STRETCH_CYCLES);
        end else if (stretch_reg != 8'h00) begin
            stretch_reg <= stretch_reg - 8'h01;
        end
    end

    // Transmit shift register, least significant byte of the word first
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_reg <= 8'hFF;
        end else if (stretch_reg == 8'h02) begin
            tx_reg <= word_reg[8*byte_idx_reg +: 8];
        end else if (state_reg == ST_SEND && scl_fall) begin
            tx_reg <= {tx_reg[6:0], 1'b1};
        end
    end

    // Open-drain pin drivers; enable low pulls the line low
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_n <= (stretch_reg == 8'h00);
            case (state_reg)
                ST_ADDR_ACK, ST_RECV_ACK: sda_oe_n <= 1'b0;
                ST_SEND: sda_oe_n <= (stretch_reg > 8'h01) | tx_reg[7]; // Bit settles before SCL
                default: sda_oe_n <= 1'b1;
            endcase
        end
    end

endmodule // osc_status_i2c

// ===== core/osc_status_pkg.sv
package osc_status_pkg;

    // Own bus address: fixed upper bits, low nibble from the option strap
    localparam logic [6:0] TARGET_ADDR_BASE = 7'h60;
    localparam int OPTION_LSB = 0;
    localparam int OPTION_W = 4;

    // Status register numbers
    localparam logic [7:0] REG_UPTIME = 8'hA0;
    localparam logic [7:0] REG_RESONATOR_TEMP = 8'hA1;
    localparam logic [7:0] REG_SUPPLY_VOLTS = 8'hA3;
    localparam logic [7:0] REG_HEATER_POWER_NOW = 8'hA7;
    localparam logic [7:0] REG_COMBINED_OFFSET = 8'hAB;
    localparam logic [7:0] REG_FAULT_INDICATOR = 8'hAE;
    localparam logic [7:0] REG_OVEN_SETTLED = 8'hAF;
    localparam logic [7:0] REG_THERMAL_LOOP_ERROR = 8'hB0;
    localparam logic [7:0] REG_HEATER_POWER_GOAL = 8'hB1;

    // Register numbers sharing these upper bits form one group
    localparam int GROUP_LSB = 5;

    // Fault-clear sequence: register number, then two data bytes
    localparam logic [7:0] CLEAR_REG = 8'hE1;
    localparam logic [7:0] CLEAR_BYTE0 = 8'h64;
    localparam logic [7:0] CLEAR_BYTE1 = 8'h01;

    // Reset and normal values
    localparam logic [31:0] FAULT_NORMAL = 32'h0000_0007;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    // Index of the last byte of a status register
    localparam logic [1:0] LAST_BYTE = 2'h3;

    // Timing
    localparam int MCLK_HZ = 250_000_000;
    localparam int REFRESH_HZ = 1000;
    localparam int REFRESH_CYCLES = MCLK_HZ / REFRESH_HZ;
    localparam int TICKS_PER_SECOND = REFRESH_HZ;
    localparam int MCLK_PERIOD_NS = 4;
    localparam int STRETCH_NS = 40;
    localparam int STRETCH_CYCLES = (STRETCH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int MAX_SCL_HZ = 400_000;

    // Single precision float layout
    typedef struct packed {
        logic sign;
        logic [7:0] exponent;
        logic [22:0] fraction;
    } float_s;

    // Live values from the oven control logic
    typedef struct packed {
        float_s resonator_temp;
        float_s supply_volts;
        float_s heater_power_now;
        float_s combined_offset;
        logic oven_settled;
        float_s thermal_loop_error;
        float_s heater_power_goal;
    } status_live_s;

endpackage

// ===== core/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous inputs
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // pin_sync

// ===== dv/i2c_ctl.sv
`timescale 1ns/1ps
// Bus controller model; a drive of 1 releases the open-drain line
module i2c_ctl (
    // Clock
    input wire logic mclk,
    // Wire levels
    input wire logic scl_line,
    input wire logic sda_line,
    // Open-drain drives
    output logic scl_rel,
    output logic sda_rel
);
    int timeouts = 0;
    int stretches = 0;
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Release SCL and wait, under a bound, while the target stretches it
    task automatic scl_up();
        int n = 0;
        scl_rel = 1'b1;
        #1;
        while (scl_line !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n > 0) stretches++;
        if (n == 200) timeouts++;
    endtask
    // One clock pulse: bit set in the low phase, line sampled mid-high
    task automatic pulse(input logic b, output logic r);
        gap(4);
        sda_rel = b;
        gap(4);
        scl_up();
        gap(4);
        r = sda_line;
        gap(4);
        scl_rel = 1'b0;
    endtask
    // START or repeated START
    task automatic start();
        gap(4);
        sda_rel = 1'b1;
        gap(4);
        scl_up();
        gap(8);
        sda_rel = 1'b0;
        gap(8);
        scl_rel = 1'b0;
    endtask
    // STOP, then bus idle
    task automatic stop();
        gap(4);
        sda_rel = 1'b0;
        gap(4);
        scl_up();
        gap(8);
        sda_rel = 1'b1;
        gap(16);
    endtask
    task automatic send(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) pulse(d[i], r);
        pulse(1'b1, nak);
    endtask
    // Every received byte is acknowledged, the last one too
    task automatic recv(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
        pulse(1'b0, r);
    endtask
endmodule // i2c_ctl

// ===== dv/osc_status_i2c_monitor.sv
`timescale 1ns/1ps
// Pin discipline, stretch length and pulse timing at the ports
module osc_status_i2c_monitor
    import osc_status_pkg::*;
#(
    parameter int REFRESH_DIV = REFRESH_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Bus pins
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    // Pulses
    input wire logic refresh_tick,
    input wire logic fault_clear
);
    int gap;
    logic seen;
    logic scl_q;
    logic sda_q;
    int since_stop;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Cycles since the last refresh pulse
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gap <= 0;
            seen <= 1'b0;
        end else begin
            gap <= refresh_tick ? 0 : gap + 1;
            seen <= seen | refresh_tick;
        end
    end
    // Cycles since a STOP on the raw pins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            since_stop <= 255;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            if (scl_i && scl_q && sda_i && !sda_q) since_stop <= 0;
            else if (since_stop < 255) since_stop <= since_stop + 1;
        end
    end
    pull_only_a: assert property (!scl_o && !sda_o)
        else $error("device drove a bus pin high");
    tick_period_a: assert property (refresh_tick && seen |-> gap == REFRESH_DIV - 1)
        else $error("refresh period wrong");
    tick_single_a: assert property (refresh_tick |=> !refresh_tick)
        else $error("refresh pulse too long");
    sda_hold_a: assert property ($changed(sda_oe_n) |-> !scl_i)
        else $error("SDA drive changed while SCL high");
    stretch_start_a: assert property ($fell(scl_oe_n) |-> !scl_i)
        else $error("stretch began while SCL high");
    stretch_len_a: assert property ($fell(scl_oe_n) |-> (!scl_oe_n)[*8] ##[1:4] scl_oe_n)
        else $error("stretch length wrong");
    clear_pulse_a: assert property (fault_clear |=> !fault_clear)
        else $error("clear pulse too long");
    clear_stop_a: assert property (fault_clear |-> since_stop <= 16)
        else $error("clear without a recent STOP");
    cover property (fault_clear);
    cover property ($fell(scl_oe_n));
    cover property ($fell(sda_oe_n));
endmodule // osc_status_i2c_monitor
bind osc_status_i2c osc_status_i2c_monitor #(.REFRESH_DIV(REFRESH_DIV)) u_osc_status_i2c_monitor (
    .mclk(mclk), .resetn(resetn), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .refresh_tick(refresh_tick),
    .fault_clear(fault_clear));

// ===== dv/osc_status_i2c_tb_top.sv
`timescale 1ns/1ps
module osc_status_i2c_tb_top;
    import osc_status_pkg::*;
    localparam int DIV = 32;
    logic mclk;
    logic resetn;
    logic [OPTION_W-1:0] addr_option;
    status_live_s status_live;
    logic [31:0] fault_code;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, refresh_tick, fault_clear;
    logic scl_rel, sda_rel, scl_line, sda_line;
    logic [6:0] own;
    logic [63:0] rd, u0;
    logic [3:0] nak;
    logic [7:0] nums [7] = '{8'hA1, 8'hA3, 8'hA7, 8'hAB, 8'hB0, 8'hB1, 8'hA2};
    int miscompares = 0;
    int comparisons = 0;
    int clears = 0;
    // Wired-AND bus with pull-ups
    assign scl_line = scl_rel & (scl_oe_n | scl_o);
    assign sda_line = sda_rel & (sda_oe_n | sda_o);
    assign own = TARGET_ADDR_BASE | {3'h0, addr_option};
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (fault_clear === 1'b1) clears++;
    end
    osc_status_i2c #(.REFRESH_DIV(DIV)) u_osc_status_i2c (
        .mclk(mclk), .resetn(resetn), .addr_option(addr_option), .status_live(status_live),
        .fault_code(fault_code), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .refresh_tick(refresh_tick),
        .fault_clear(fault_clear));
    i2c_ctl u_i2c_ctl (.mclk(mclk), .scl_line(scl_line), .sda_line(sda_line),
        .scl_rel(scl_rel), .sda_rel(sda_rel));
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] val(input logic [7:0] num);
        case (num)
            REG_RESONATOR_TEMP: return status_live.resonator_temp;
            REG_SUPPLY_VOLTS: return status_live.supply_volts;
            REG_HEATER_POWER_NOW: return status_live.heater_power_now;
            REG_COMBINED_OFFSET: return status_live.combined_offset;
            REG_OVEN_SETTLED: return {31'h0, status_live.oven_settled};
            REG_THERMAL_LOOP_ERROR: return status_live.thermal_loop_error;
            REG_HEATER_POWER_GOAL: return status_live.heater_power_goal;
            default: return 32'h0;
        endcase
    endfunction
    // Write the register number, then read n bytes after Sr or P,S
    task automatic rd_reg(input logic [7:0] num, input int n, input logic rs);
        logic [2:0] a;
        logic [7:0] b;
        rd = '0;
        u_i2c_ctl.start();
        u_i2c_ctl.send({own, 1'b0}, a[2]);
        u_i2c_ctl.send(num, a[1]);
        if (!rs) u_i2c_ctl.stop();
        u_i2c_ctl.start();
        u_i2c_ctl.send({own, 1'b1}, a[0]);
        check({61'h0, a}, 64'h0);
        for (int i = 0; i < n; i++) begin
            u_i2c_ctl.recv(b);
            rd[8*i +: 8] = b;
        end
        u_i2c_ctl.stop();
    endtask
    // Register number and two data bytes; abandoned after an address NACK
    task automatic wr_reg(input logic [6:0] adr, input logic [7:0] num, input logic [15:0] d);
        nak = 4'hF;
        u_i2c_ctl.start();
        u_i2c_ctl.send({adr, 1'b0}, nak[3]);
        if (nak[3] === 1'b0) begin
            u_i2c_ctl.send(num, nak[2]);
            u_i2c_ctl.send(d[7:0], nak[1]);
            u_i2c_ctl.send(d[15:8], nak[0]);
        end
        u_i2c_ctl.stop();
    endtask
    task automatic test_done();
        miscompares += u_i2c_ctl.timeouts;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        test_done();
    end
    initial begin
        resetn = 1'b0;
        addr_option = 4'h5;
        fault_code = FAULT_NORMAL;
        status_live = {32'h4228_0000, 32'h4053_3333, 32'h3FC0_0000, 32'h3586_37BD, 1'b1,
            32'hBC23_D70A, 32'h4000_0000};
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        repeat (8) @(negedge mclk);
        rd_reg(REG_FAULT_INDICATOR, 4, 1'b1);
        check(rd, {32'h0, FAULT_NORMAL});
        foreach (nums[i]) begin
            rd_reg(nums[i], 4, 1'(i % 2));
            check(rd, {32'h0, val(nums[i])});
        end
        // Read across two registers of one group
        rd_reg(REG_OVEN_SETTLED, 8, 1'b0);
        check(rd, {val(REG_THERMAL_LOOP_ERROR), val(REG_OVEN_SETTLED)});
        check({63'h0, u_i2c_ctl.stretches > 0}, 64'h1);
        // Writes are acknowledged but change nothing; a foreign address is refused
        wr_reg(own, REG_RESONATOR_TEMP, 16'h5AA5);
        check({60'h0, nak}, 64'h0);
        rd_reg(REG_RESONATOR_TEMP, 4, 1'b0);
        check(rd, {32'h0, val(REG_RESONATOR_TEMP)});
        wr_reg(own ^ 7'h01, REG_RESONATOR_TEMP, 16'h0000);
        check({60'h0, nak}, 64'h0F);
        // First fault sticks until the clear sequence
        fault_code = 32'h0000_0003;
        repeat (2 * DIV) @(negedge mclk);
        fault_code = 32'h0000_0005;
        repeat (2 * DIV) @(negedge mclk);
        fault_code = FAULT_NORMAL;
        repeat (2 * DIV) @(negedge mclk);
        rd_reg(REG_FAULT_INDICATOR, 4, 1'b0);
        check(rd, 64'h3);
        wr_reg(own, CLEAR_REG, {CLEAR_BYTE1, CLEAR_BYTE0});
        repeat (8) @(negedge mclk);
        check({60'h0, nak}, 64'h0);
        check(64'(clears), 64'h1);
        repeat (2 * DIV) @(negedge mclk);
        rd_reg(REG_FAULT_INDICATOR, 4, 1'b1);
        check(rd, {32'h0, FAULT_NORMAL});
        // New address option, uptime advances once per thousand refreshes
        addr_option = 4'hA;
        rd_reg(REG_UPTIME, 4, 1'b0);
        u0 = rd;
        repeat (1000 * DIV) @(negedge mclk);
        rd_reg(REG_UPTIME, 4, 1'b1);
        check({63'h0, (rd - u0 == 64'h1) || (rd - u0 == 64'h2)}, 64'h1);
        test_done();
    end
endmodule // osc_status_i2c_tb_top
